// *** core/lcgis_pkg.sv ***
// constants of the logic cell gate input select stage
package lcgis_pkg;
  // ==========================================================
  // geometry
  localparam int unsigned N_GATES  = 3;
  localparam int unsigned N_DIN    = 4;
  localparam int unsigned SEL_W    = 6;
  localparam int unsigned SRC_N    = 64;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned ADDR_W   = 4;
  // ==========================================================
  // select byte layout: input k true at 2k+1, inverted at 2k
  localparam int unsigned TRUE_OFS = 1;
  localparam int unsigned INV_OFS  = 0;
  // ==========================================================
  // register map
  localparam logic [ADDR_W-1:0] A_GATE0_SEL = 4'h0;
  localparam logic [ADDR_W-1:0] A_GATE1_SEL = 4'h1;
  localparam logic [ADDR_W-1:0] A_GATE2_SEL = 4'h2;
  localparam logic [ADDR_W-1:0] A_GATE_POL  = 4'h3;
  localparam logic [ADDR_W-1:0] A_DSRC0     = 4'h4;
  localparam logic [ADDR_W-1:0] A_DSRC1     = 4'h5;
  localparam logic [ADDR_W-1:0] A_DSRC2     = 4'h6;
  localparam logic [ADDR_W-1:0] A_DSRC3     = 4'h7;
  localparam logic [ADDR_W-1:0] A_STATUS    = 4'h8;
  // ==========================================================
  // power-on values (documented as unknown; any value is legal)
  localparam logic [DATA_W-1:0] GLS_POR     = 8'h00;
  localparam logic [SEL_W-1:0]  DSRC_POR    = 6'h00;
  localparam logic [N_GATES-1:0] POL_POR    = 3'h0;
  localparam logic [DATA_W-1:0] RD_ZERO     = 8'h00;
endpackage : lcgis_pkg

// *** core/lcgis_gate.sv ***
// one gate: or of enabled true/inverted data terms, then polarity
`timescale 1ns/1ps
`default_nettype none
module lcgis_gate (
  // select and polarity
  input  wire logic [lcgis_pkg::DATA_W-1:0] i_sel,
  input  wire logic                         i_invert,
  // cell data inputs
  input  wire logic [lcgis_pkg::N_DIN-1:0]  i_din,
  // gate result
  output logic                              o_gate
);
  function automatic logic term_or(input logic [lcgis_pkg::DATA_W-1:0] sel,
                                   input logic [lcgis_pkg::N_DIN-1:0] din);
    logic acc;
    acc = 1'b0;
    for (int k = 0; k < lcgis_pkg::N_DIN; k++) begin
      acc = acc | (sel[2*k+lcgis_pkg::TRUE_OFS] & din[k]);
      acc = acc | (sel[2*k+lcgis_pkg::INV_OFS] & ~din[k]);
    end
    return acc;
  endfunction : term_or

  // empty select gives zero before polarity
  assign o_gate = term_or(i_sel, i_din) ^ i_invert;
endmodule : lcgis_gate
`default_nettype wire

// *** core/lcgis_top.sv ***
// gate input select stage with its register port
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - gate 0 takes inputs 3..0 true when its select bits 7,5,3,1 are set.
// - gate 0 takes inputs 3..0 inverted when its select bits 6,4,2,0 are set.
// - gate 1 takes inputs 3..0 true when its select bits 7,5,3,1 are set.
// - gate 1 takes inputs 3..0 inverted when its select bits 6,4,2,0 are set.
// - gate 2 takes inputs 3..0 true when its select bits 7,5,3,1 are set.
// - gate 2 takes inputs 3..0 inverted when its select bits 6,4,2,0 are set.
// - select bits are read/write, unknown at power-on and kept over other resets.
// - a set gate polarity bit inverts that gate's output.
// - each cell data input comes from a source picked by its own six-bit field.
module lcgis_top (
  // clock and reset
  input  wire logic                                i_sys_clk,
  input  wire logic                                i_arst_n,
  // register port
  input  wire logic [lcgis_pkg::ADDR_W-1:0]        i_addr,
  input  wire logic [lcgis_pkg::DATA_W-1:0]        i_wdata,
  input  wire logic                                i_wr,
  input  wire logic                                i_rd,
  output logic      [lcgis_pkg::DATA_W-1:0]        o_rdata,
  // signal sources
  input  wire logic [lcgis_pkg::SRC_N-1:0]         i_src,
  // cell data inputs and gate outputs
  output logic      [lcgis_pkg::N_DIN-1:0]         o_cell_data_in,
  output logic      [lcgis_pkg::N_GATES-1:0]       o_gate_out
);
  typedef struct packed {
    logic [lcgis_pkg::N_GATES-1:0][lcgis_pkg::DATA_W-1:0] gls;
    logic [lcgis_pkg::N_GATES-1:0]                        pol;
    logic [lcgis_pkg::N_DIN-1:0][lcgis_pkg::SEL_W-1:0]    dsrc;
    logic [lcgis_pkg::DATA_W-1:0]                         rdata;
    logic [lcgis_pkg::N_DIN-1:0]                          din;
    logic [lcgis_pkg::N_GATES-1:0]                        gate;
  } lcgis_state_t;

  lcgis_state_t                    st;
  lcgis_state_t                    next_st;
  logic [lcgis_pkg::N_DIN-1:0]     cell_din;
  logic [lcgis_pkg::N_GATES-1:0]   gate_now;

  // ==========================================================
  // data input source selection
  always_comb begin
    for (int k = 0; k < lcgis_pkg::N_DIN; k++) begin
      cell_din[k] = i_src[st.dsrc[k]];
    end
  end

  // ==========================================================
  // gates
  for (genvar g = 0; g < lcgis_pkg::N_GATES; g++) begin : g_gate
    lcgis_gate u_gate (
      .i_sel    (st.gls[g]),
      .i_invert (st.pol[g]),
      .i_din    (cell_din),
      .o_gate   (gate_now[g])
    );
  end

  // ==========================================================
  // register port and state update
  always_comb begin
    next_st      = st;
    next_st.din  = cell_din;
    next_st.gate = gate_now;
    next_st.rdata = lcgis_pkg::RD_ZERO;
    if (i_wr) begin
      case (i_addr)
        lcgis_pkg::A_GATE0_SEL: next_st.gls[0]  = i_wdata;
        lcgis_pkg::A_GATE1_SEL: next_st.gls[1]  = i_wdata;
        lcgis_pkg::A_GATE2_SEL: next_st.gls[2]  = i_wdata;
        lcgis_pkg::A_GATE_POL:  next_st.pol     = i_wdata[lcgis_pkg::N_GATES-1:0];
        lcgis_pkg::A_DSRC0:     next_st.dsrc[0] = i_wdata[lcgis_pkg::SEL_W-1:0];
        lcgis_pkg::A_DSRC1:     next_st.dsrc[1] = i_wdata[lcgis_pkg::SEL_W-1:0];
        lcgis_pkg::A_DSRC2:     next_st.dsrc[2] = i_wdata[lcgis_pkg::SEL_W-1:0];
        lcgis_pkg::A_DSRC3:     next_st.dsrc[3] = i_wdata[lcgis_pkg::SEL_W-1:0];
        default: ;
      endcase
    end
    if (i_rd) begin
      case (i_addr)
        lcgis_pkg::A_GATE0_SEL: next_st.rdata = st.gls[0];
        lcgis_pkg::A_GATE1_SEL: next_st.rdata = st.gls[1];
        lcgis_pkg::A_GATE2_SEL: next_st.rdata = st.gls[2];
        lcgis_pkg::A_GATE_POL:  next_st.rdata = {5'h00, st.pol};
        lcgis_pkg::A_DSRC0:     next_st.rdata = {2'h0, st.dsrc[0]};
        lcgis_pkg::A_DSRC1:     next_st.rdata = {2'h0, st.dsrc[1]};
        lcgis_pkg::A_DSRC2:     next_st.rdata = {2'h0, st.dsrc[2]};
        lcgis_pkg::A_DSRC3:     next_st.rdata = {2'h0, st.dsrc[3]};
        lcgis_pkg::A_STATUS:    next_st.rdata = {1'h0, st.gate, st.din};
        default:                next_st.rdata = lcgis_pkg::RD_ZERO;
      endcase
    end
  end

  // power-on reset only; no other reset touches the selects
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st.gls   <= {lcgis_pkg::N_GATES{lcgis_pkg::GLS_POR}};
      st.pol   <= lcgis_pkg::POL_POR;
      st.dsrc  <= {lcgis_pkg::N_DIN{lcgis_pkg::DSRC_POR}};
      st.rdata <= lcgis_pkg::RD_ZERO;
      st.din   <= 4'h0;
      st.gate  <= 3'h0;
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata        = st.rdata;
  assign o_cell_data_in = st.din;
  assign o_gate_out     = st.gate;

  // ==========================================================
  // assertions
  logic src_pick1;
  assign src_pick1 = i_src[st.dsrc[1]];

  property p_g0_true;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      (st.gls[0][7] && cell_din[3] && !st.pol[0]) |=> o_gate_out[0];
  endproperty
  a_g0_true: assert property (p_g0_true) else $error("gate0 true term lost");

  property p_g0_inv;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      (st.gls[0] == 8'h40 && cell_din[3] && !st.pol[0]) |=> !o_gate_out[0];
  endproperty
  a_g0_inv: assert property (p_g0_inv) else $error("gate0 inverted term wrong");

  property p_g1_true;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      (st.gls[1] == 8'h20 && !st.pol[1]) |=> (o_gate_out[1] == o_cell_data_in[2]);
  endproperty
  a_g1_true: assert property (p_g1_true) else $error("gate1 true term wrong");

  property p_g1_inv;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      (st.gls[1] == 8'h10 && !st.pol[1]) |=> (o_gate_out[1] != o_cell_data_in[2]);
  endproperty
  a_g1_inv: assert property (p_g1_inv) else $error("gate1 inverted term wrong");

  property p_g2_true;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      (st.gls[2] == 8'h02 && !st.pol[2]) |=> (o_gate_out[2] == o_cell_data_in[0]);
  endproperty
  a_g2_true: assert property (p_g2_true) else $error("gate2 true term wrong");

  property p_g2_inv;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      (st.gls[2] == 8'h01 && !st.pol[2]) |=> (o_gate_out[2] != o_cell_data_in[0]);
  endproperty
  a_g2_inv: assert property (p_g2_inv) else $error("gate2 inverted term wrong");

  property p_rw;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      (i_wr && i_addr == lcgis_pkg::A_GATE1_SEL) ##1 (i_rd && i_addr == lcgis_pkg::A_GATE1_SEL)
      |=> (o_rdata == $past(i_wdata, 2));
  endproperty
  a_rw: assert property (p_rw) else $error("gate1 select readback wrong");

  property p_pol;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      (st.gls[0] == 8'h00) |=> (o_gate_out[0] == $past(st.pol[0]));
  endproperty
  a_pol: assert property (p_pol) else $error("gate0 polarity wrong");

  property p_src;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      (st.gls[1] == 8'h08 && !st.pol[1]) |=> (o_gate_out[1] == $past(src_pick1));
  endproperty
  a_src: assert property (p_src) else $error("data input source wrong");

  property p_empty;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      (st.gls[2] == 8'h00 && !st.pol[2]) ##1 (st.gls[2] == 8'h00 && !st.pol[2])
      |=> !o_gate_out[2];
  endproperty
  a_empty: assert property (p_empty) else $error("empty gate not zero");

  property p_g0_ninv;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      (st.gls[0][6] && !cell_din[3] && !st.pol[0]) |=> o_gate_out[0];
  endproperty
  a_g0_ninv: assert property (p_g0_ninv) else $error("gate0 inverted term lost");

  property p_g1_term;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      (st.gls[1][5] && cell_din[2] && !st.pol[1]) |=> o_gate_out[1];
  endproperty
  a_g1_term: assert property (p_g1_term) else $error("gate1 true term lost");

  property p_hold;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      (!i_wr) |=> $stable(st.gls);
  endproperty
  a_hold: assert property (p_hold) else $error("select changed without write");

  property p_rd_idle;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      (!i_rd) |=> (o_rdata == lcgis_pkg::RD_ZERO);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");

  property p_g2_pol;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      (st.gls[2] == 8'hFF) |=> (o_gate_out[2] == !$past(st.pol[2]));
  endproperty
  a_g2_pol: assert property (p_g2_pol) else $error("gate2 polarity wrong");

  c_g0_on:  cover property (@(posedge i_sys_clk) disable iff (!i_arst_n) o_gate_out[0]);
  c_g2_inv: cover property (@(posedge i_sys_clk) disable iff (!i_arst_n)
                            st.pol[2] && o_gate_out[2]);
  c_rd_st:  cover property (@(posedge i_sys_clk) disable iff (!i_arst_n)
                            i_rd && i_addr == lcgis_pkg::A_STATUS);
  c_wr_rd:  cover property (@(posedge i_sys_clk) disable iff (!i_arst_n)
                            i_wr ##1 i_rd);
  c_empty:  cover property (@(posedge i_sys_clk) disable iff (!i_arst_n)
                            st.gls[2] == 8'h00 && !o_gate_out[2]);
endmodule : lcgis_top
`default_nettype wire

// *** verif/lcgis_tb_top.sv ***
// self-checking testbench of the gate input select stage
`timescale 1ns/1ps
`default_nettype none
module lcgis_tb_top;
  // ==========================================================
  // clock, reset and design ports
  logic        i_sys_clk = 1'b0;
  logic        i_arst_n  = 1'b0;
  logic [3:0]  i_addr    = 4'h0;
  logic [7:0]  i_wdata   = 8'h00;
  logic        i_wr      = 1'b0;
  logic        i_rd      = 1'b0;
  logic [63:0] i_src     = 64'h0;
  logic [7:0]  o_rdata;
  logic [3:0]  o_cell_data_in;
  logic [2:0]  o_gate_out;
  int          num_errors  = 0;
  int          checks_done = 0;
  logic [7:0]  rd_val;
  logic [2:0]  exp_g;
  always #10 i_sys_clk = ~i_sys_clk;
  lcgis_top dut_u (
    .i_sys_clk      (i_sys_clk),
    .i_arst_n       (i_arst_n),
    .i_addr         (i_addr),
    .i_wdata        (i_wdata),
    .i_wr           (i_wr),
    .i_rd           (i_rd),
    .o_rdata        (o_rdata),
    .i_src          (i_src),
    .o_cell_data_in (o_cell_data_in),
    .o_gate_out     (o_gate_out)
  );
  // ==========================================================
  // bus tasks and compare
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask : rd
  // write then read with no idle cycle between the strobes
  task automatic wr_rd(input logic [3:0] a, input logic [7:0] dw, output logic [7:0] d);
    @(posedge i_sys_clk);
    i_addr  <= a;
    i_wdata <= dw;
    i_wr    <= 1'b1;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask : wr_rd
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic settle(input logic [63:0] s);
    @(posedge i_sys_clk);
    i_src <= s;
    repeat (3) @(posedge i_sys_clk);
    #1;
  endtask : settle
  task automatic results;
    $display("checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results
  initial begin
    #2000000 num_errors++;
    results();
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (6) @(posedge i_sys_clk);
    i_arst_n <= 1'b1;
    // select registers read back what was written
    for (int r = 0; r < 3; r++) begin
      wr(r[3:0], 8'hA5 ^ r[7:0]);
      wr(r[3:0], 8'h5A ^ r[7:0]);
    end
    wr(4'hF, 8'hFF);
    for (int r = 0; r < 3; r++) begin
      rd(r[3:0], rd_val);
      chk(rd_val, 8'h5A ^ r[7:0], "select readback");
    end
    rd(4'hF, rd_val);
    chk(rd_val, 8'h00, "unmapped read");
    wr_rd(lcgis_pkg::A_GATE1_SEL, 8'h3C, rd_val);
    chk(rd_val, 8'h3C, "write then read");
    @(posedge i_sys_clk);
    #1 chk(o_rdata, 8'h00, "read data one cycle");
    $display("test register access done");
    // data sources: each field picks its own source line
    wr(lcgis_pkg::A_DSRC0, 8'h3F);
    wr(lcgis_pkg::A_DSRC1, 8'h2A);
    wr(lcgis_pkg::A_DSRC2, 8'h15);
    wr(lcgis_pkg::A_DSRC3, 8'h00);
    settle(64'h8000_0400_0020_0001);
    chk({4'h0, o_cell_data_in}, 8'h0F, "sources set");
    settle(~64'h8000_0400_0020_0001);
    chk({4'h0, o_cell_data_in}, 8'h00, "sources clear");
    $display("test source select done");
    // every single select bit of every gate, all input values
    for (int k = 0; k < 4; k++) wr(lcgis_pkg::A_DSRC0 + k[3:0], k[7:0]);
    wr(lcgis_pkg::A_GATE_POL, 8'h00);
    for (int g = 0; g < 3; g++) begin
      for (int b = 0; b < 8; b++) begin
        for (int r = 0; r < 3; r++) wr(r[3:0], (r == g) ? (8'h01 << b) : 8'h00);
        for (int d = 0; d < 16; d++) begin
          settle({60'h0, d[3:0]});
          exp_g = 3'h0;
          exp_g[g] = b[0] ? d[b/2] : ~d[b/2];
          chk({5'h0, o_gate_out}, {5'h0, exp_g}, "single term");
        end
      end
    end
    $display("test single terms done");
    // several terms are or-ed, empty gate with polarity set is one, polarity inverts
    wr(lcgis_pkg::A_GATE0_SEL, 8'h81);
    wr(lcgis_pkg::A_GATE1_SEL, 8'h00);
    wr(lcgis_pkg::A_GATE2_SEL, 8'hFF);
    wr(lcgis_pkg::A_GATE_POL, 8'h03);
    for (int d = 0; d < 16; d++) begin
      settle({60'h0, d[3:0]});
      exp_g = {1'b1, 1'b1, ~(d[3] | ~d[0])};
      chk({5'h0, o_gate_out}, {5'h0, exp_g}, "or and polarity");
    end
    rd(lcgis_pkg::A_GATE_POL, rd_val);
    chk(rd_val, 8'h03, "polarity readback");
    rd(lcgis_pkg::A_DSRC3, rd_val);
    chk(rd_val, 8'h03, "source field readback");
    rd(lcgis_pkg::A_STATUS, rd_val);
    chk(rd_val, 8'h6F, "status gates and inputs");
    $display("test or and polarity done");
    results();
  end
endmodule : lcgis_tb_top
`default_nettype wire
